/* File: rtl/scg_sleep_gate_ctrl.sv */
// Sleep mode clock gate enable register with AXI4-Lite slave and unit gating
// Notes on behaviour
// - Set enable clocks unit in sleep
// - Clear enable stops unit clock
// - Access to stopped unit gives bus fault
// - All enables reset to zero
// - Sleep register applies only in sleep
// - Sleep gating needs auto gate select
// - Bit 30 PHY, bit 28 MAC
// - Bits 6..0 ports G down to A
// - Reserved bits read zero, writes ignored
// - Decoded at base plus 0x118
`timescale 1ns/10ps
`default_nettype none
module scg_sleep_gate_ctrl #(
   parameter int UNITS = 9
) (
   input wire logic aclk, // System clock, 20 MHz
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic [31:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [31:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic [1:0] power_mode, // Current power mode from power manager
   input wire logic unit_req_valid, // Peripheral bus access to a gated unit
   input wire logic [8:0] unit_req_sel, // One-hot unit select of that access
   output logic unit_req_fault, // Bus fault for an access to a stopped unit
   output logic [8:0] unit_clk_en, // Clock enables for gated units, registered
   output logic irq // Level interrupt
);
   // Unit index layout of unit_clk_en: [6:0] ports A..G, [7] MAC, [8] PHY

   logic [31:0] sleep_gate_reg, sleep_gate_next;
   logic [31:0] run_gate_reg, run_gate_next;
   logic [31:0] deep_sleep_gate_reg, deep_sleep_gate_next;
   logic [31:0] run_clock_config_reg, run_clock_config_next;
   logic [1:0] irq_stat_reg, irq_stat_next;
   logic [1:0] irq_mask_reg, irq_mask_next;
   logic [8:0] unit_clk_en_reg;
   logic aw_held_reg, w_held_reg;
   logic [31:0] awaddr_reg, wdata_reg;
   logic [3:0] wstrb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   scg_pkg::scg_rd_state_t rd_state_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   scg_pkg::scg_unit_req_t unit_req;

   // Map a 32-bit gate register onto the unit enable vector
   function automatic logic [8:0] gate_units(input logic [31:0] r);
      gate_units = {r[scg_pkg::PHY_BIT], r[scg_pkg::MAC_BIT],
                    r[scg_pkg::PORT_LSB + scg_pkg::PORT_CNT - 1:scg_pkg::PORT_LSB]};
   endfunction

   // Byte-lane merge with write mask; reserved bits stay zero
   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb, input logic [31:0] wmask);
      logic [31:0] lanes;
      lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      merge = ((old_v & ~lanes) | (new_v & lanes)) & wmask;
   endfunction

   // Register offset match within the block base
   function automatic logic hit(input logic [31:0] addr, input logic [11:0] ofs);
      hit = (addr[31:12] == scg_pkg::BASE_ADDR[31:12]) && (addr[11:0] == ofs);
   endfunction

   // Write channel: both halves captured, then applied in one cycle
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire aw_now = aw_held_reg || aw_take;
   wire w_now = w_held_reg || w_take;
   wire [31:0] wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
   wire [31:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
   wire [3:0] wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
   wire wr_fire = aw_now && w_now && !bvalid_reg;
   assign s_axi_awready = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready = !w_held_reg && !bvalid_reg;

   // Write decode
   wire wr_sleep = wr_fire && hit(wr_addr, scg_pkg::SLEEP_GATE_OFS);
   wire wr_run = wr_fire && hit(wr_addr, scg_pkg::RUN_GATE_OFS);
   wire wr_deep = wr_fire && hit(wr_addr, scg_pkg::DEEP_GATE_OFS);
   wire wr_cfg = wr_fire && hit(wr_addr, scg_pkg::RUN_CFG_OFS);
   wire wr_mask = wr_fire && hit(wr_addr, scg_pkg::IRQ_MASK_OFS);
   wire wr_known = wr_sleep || wr_run || wr_deep || wr_cfg || wr_mask;

   // Next register values; reserved bits masked to zero
   assign sleep_gate_next = wr_sleep ? merge(sleep_gate_reg, wr_data, wr_strb, scg_pkg::GATE_WMASK)
                                     : sleep_gate_reg;
   assign run_gate_next = wr_run ? merge(run_gate_reg, wr_data, wr_strb, scg_pkg::GATE_WMASK)
                                 : run_gate_reg;
   assign deep_sleep_gate_next = wr_deep ? merge(deep_sleep_gate_reg, wr_data, wr_strb, scg_pkg::GATE_WMASK)
                                         : deep_sleep_gate_reg;
   assign run_clock_config_next = wr_cfg ? merge(run_clock_config_reg, wr_data, wr_strb, scg_pkg::RUN_CFG_WMASK)
                                         : run_clock_config_reg;
   assign irq_mask_next = wr_mask && wr_strb[0] ? wr_data[scg_pkg::IRQ_W-1:0] : irq_mask_reg;

   // Gate selection: sleep set only in sleep with auto gating on
   wire auto_gate_select = run_clock_config_reg[scg_pkg::AUTO_GATE_BIT];
   wire in_sleep = power_mode == scg_pkg::MODE_SLEEP;
   wire in_deep = power_mode == scg_pkg::MODE_DEEP;
   wire [31:0] active_gate = !auto_gate_select ? run_gate_reg
                           : in_sleep ? sleep_gate_reg
                           : in_deep ? deep_sleep_gate_reg
                           : run_gate_reg;
   wire [8:0] en_next = gate_units(active_gate);

   // Unit access fault check against the enables currently applied
   assign unit_req = '{valid: unit_req_valid, sel: unit_req_sel};
   assign unit_req_fault = unit_req.valid && |(unit_req.sel & ~unit_clk_en_reg);

   // Read channel decode
   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire [11:0] rofs = s_axi_araddr[11:0];
   wire rd_base = s_axi_araddr[31:12] == scg_pkg::BASE_ADDR[31:12];
   wire rd_stat = rd_base && rofs == scg_pkg::IRQ_STAT_OFS;
   logic [31:0] rd_val;
   logic rd_ok;
   always_comb begin
      rd_ok = rd_base;
      case (rofs)
         scg_pkg::SLEEP_GATE_OFS: rd_val = sleep_gate_reg;
         scg_pkg::RUN_GATE_OFS: rd_val = run_gate_reg;
         scg_pkg::DEEP_GATE_OFS: rd_val = deep_sleep_gate_reg;
         scg_pkg::RUN_CFG_OFS: rd_val = run_clock_config_reg;
         scg_pkg::IRQ_STAT_OFS: rd_val = {30'h0, irq_stat_reg};
         scg_pkg::IRQ_MASK_OFS: rd_val = {30'h0, irq_mask_reg};
         scg_pkg::POWER_MODE_OFS: rd_val = {30'h0, power_mode};
         default: begin
            rd_val = 32'h0;
            rd_ok = 1'b0;
         end
      endcase
      // Off-block addresses read zero even where the low offset matches
      if (!rd_base) begin
         rd_val = 32'h0;
      end
   end
   assign s_axi_arready = rd_state_reg == scg_pkg::RD_IDLE;

   // Sticky events: set wins over the read clear
   wire [1:0] irq_set = {en_next != unit_clk_en_reg, unit_req_fault};
   assign irq_stat_next = ((ar_take && rd_stat) ? 2'h0 : irq_stat_reg) | irq_set;

   // Register file update
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sleep_gate_reg <= scg_pkg::GATE_RESET;
         run_gate_reg <= scg_pkg::GATE_RESET;
         deep_sleep_gate_reg <= scg_pkg::GATE_RESET;
         run_clock_config_reg <= scg_pkg::RUN_CFG_RESET;
         irq_stat_reg <= scg_pkg::IRQ_RESET;
         irq_mask_reg <= scg_pkg::IRQ_RESET;
      end else begin
         sleep_gate_reg <= sleep_gate_next;
         run_gate_reg <= run_gate_next;
         deep_sleep_gate_reg <= deep_sleep_gate_next;
         run_clock_config_reg <= run_clock_config_next;
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
      end
   end

   // Enables registered so gating cells see a clean level, never a decode glitch
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         unit_clk_en_reg <= 9'h000;
      end else begin
         unit_clk_en_reg <= en_next;
      end
   end
   assign unit_clk_en = unit_clk_en_reg;
   assign irq = |(irq_stat_reg & irq_mask_reg);

   // Write channel holding and response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= 32'h0;
         wdata_reg <= 32'h0;
         wstrb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= scg_pkg::RESP_OKAY;
      end else begin
         if (aw_take) begin
            awaddr_reg <= s_axi_awaddr;
         end
         if (w_take) begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_known ? scg_pkg::RESP_OKAY : scg_pkg::RESP_SLVERR;
         end else begin
            aw_held_reg <= aw_now;
            w_held_reg <= w_now;
            if (s_axi_bready) begin
               bvalid_reg <= 1'b0;
            end
         end
      end
   end
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;

   // Read channel state machine
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_reg <= scg_pkg::RD_IDLE;
         rdata_reg <= 32'h0;
         rresp_reg <= scg_pkg::RESP_OKAY;
      end else begin
         case (rd_state_reg)
            scg_pkg::RD_IDLE: begin
               if (ar_take) begin
                  rd_state_reg <= scg_pkg::RD_RESP;
                  rdata_reg <= rd_val;
                  rresp_reg <= rd_ok ? scg_pkg::RESP_OKAY : scg_pkg::RESP_SLVERR;
               end
            end
            scg_pkg::RD_RESP: begin
               if (s_axi_rready) begin
                  rd_state_reg <= scg_pkg::RD_IDLE;
               end
            end
            default: rd_state_reg <= scg_pkg::RD_IDLE;
         endcase
      end
   end
   assign s_axi_rvalid = rd_state_reg == scg_pkg::RD_RESP;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // Checks
   sequence sleep_write_s;
      wr_sleep ##1 (auto_gate_select && in_sleep);
   endsequence
   chk_sleep_apply: assert property (@(posedge aclk) disable iff (!aresetn)
      sleep_write_s |=> unit_clk_en == gate_units($past(sleep_gate_reg, 1)) || !$past(in_sleep, 1))
      else $error("sleep enables not applied");
   chk_gate_stop: assert property (@(posedge aclk) disable iff (!aresetn)
      (auto_gate_select && in_sleep && !sleep_gate_reg[scg_pkg::PHY_BIT]) |=> !unit_clk_en[8])
      else $error("stopped unit still clocked");
   chk_fault_stopped: assert property (@(posedge aclk) disable iff (!aresetn)
      (unit_req_valid && |(unit_req_sel & ~unit_clk_en)) |-> unit_req_fault ##1 irq_stat_reg[0])
      else $error("no fault for stopped unit");
   chk_reset_zero: assert property (@(posedge aclk)
      !aresetn |=> sleep_gate_reg == 32'h0 && unit_clk_en == 9'h0)
      else $error("enables not zero after reset");
   chk_run_outside: assert property (@(posedge aclk) disable iff (!aresetn)
      (!in_sleep && !in_deep) |=> unit_clk_en == gate_units($past(run_gate_reg, 1)))
      else $error("run set not applied");
   chk_auto_off: assert property (@(posedge aclk) disable iff (!aresetn)
      !auto_gate_select |=> unit_clk_en == gate_units($past(run_gate_reg, 1)))
      else $error("sleep set used without auto gating");
   chk_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      (sleep_gate_reg & ~scg_pkg::GATE_WMASK) == 32'h0)
      else $error("reserved bit set");
   chk_decode_write: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_fire && wr_addr == (scg_pkg::BASE_ADDR | {20'h00000, scg_pkg::SLEEP_GATE_OFS}) && wr_strb == 4'hf)
      |=> sleep_gate_reg == ($past(wr_data, 1) & scg_pkg::GATE_WMASK) ##0 s_axi_bresp == 2'h0)
      else $error("sleep register write lost");
   chk_port_bits: assert property (@(posedge aclk) disable iff (!aresetn)
      (auto_gate_select && in_sleep) [*2] |-> unit_clk_en[6:0] == $past(sleep_gate_reg[6:0], 1)
      || $past(sleep_gate_reg, 1) != $past(sleep_gate_reg, 2))
      else $error("port enables misplaced");
   chk_glitch_free: assert property (@(posedge aclk) disable iff (!aresetn)
      $stable(active_gate) ##1 $stable(active_gate) |-> $stable(unit_clk_en))
      else $error("enable changed without cause");
   // Upper enables land on the PHY and MAC units, not on reserved bits
   chk_upper_bits: assert property (@(posedge aclk) disable iff (!aresetn)
      (auto_gate_select && in_sleep) |=> unit_clk_en[8:7] == {$past(sleep_gate_reg[scg_pkg::PHY_BIT], 1),
      $past(sleep_gate_reg[scg_pkg::MAC_BIT], 1)})
      else $error("PHY or MAC enable misplaced");
   // A clocked unit must complete normally, never fault
   chk_clocked_ok: assert property (@(posedge aclk) disable iff (!aresetn)
      (unit_req_valid && (unit_req_sel & ~unit_clk_en) == 9'h000) |-> !unit_req_fault)
      else $error("fault raised for clocked unit");
   // Unknown offsets answer an error with zero data
   chk_bad_read: assert property (@(posedge aclk) disable iff (!aresetn)
      (ar_take && !rd_ok) |=> s_axi_rvalid && s_axi_rresp == scg_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
endmodule
`default_nettype wire

/* File: rtl/scg_pkg.sv */
// Package for the sleep clock gating control block: map, fields, types
package scg_pkg;
   // Register map (byte addresses within the system control block)
   localparam logic [31:0] BASE_ADDR = 32'h400f_e000;
   localparam logic [11:0] SLEEP_GATE_OFS = 12'h118;
   localparam logic [11:0] RUN_GATE_OFS = 12'h108;
   localparam logic [11:0] DEEP_GATE_OFS = 12'h128;
   localparam logic [11:0] RUN_CFG_OFS = 12'h060;
   localparam logic [11:0] IRQ_STAT_OFS = 12'h300;
   localparam logic [11:0] IRQ_MASK_OFS = 12'h304;
   localparam logic [11:0] POWER_MODE_OFS = 12'h308;
   // Gate fields
   localparam int PHY_BIT = 30;
   localparam int MAC_BIT = 28;
   localparam int PORT_LSB = 0;
   localparam int PORT_CNT = 7;
   localparam logic [31:0] GATE_WMASK = 32'h5000_007f;
   localparam logic [31:0] GATE_RESET = 32'h0000_0000;
   // Run clock configuration: auto gate select field
   localparam int AUTO_GATE_BIT = 27;
   localparam logic [31:0] RUN_CFG_WMASK = 32'h0800_0000;
   localparam logic [31:0] RUN_CFG_RESET = 32'h0000_0000;
   // Interrupt status bits
   localparam int IRQ_FAULT_BIT = 0;
   localparam int IRQ_CHANGE_BIT = 1;
   localparam int IRQ_W = 2;
   localparam logic [1:0] IRQ_RESET = 2'h0;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Power modes
   typedef enum logic [1:0] {
      MODE_RUN = 2'h0,
      MODE_SLEEP = 2'h1,
      MODE_DEEP = 2'h2
   } scg_mode_t;
   // Read channel state
   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_RESP = 2'b10
   } scg_rd_state_t;
   // Gated-unit access request carrier
   typedef struct packed {
      logic valid;
      logic [8:0] sel;
   } scg_unit_req_t;
endpackage

/* File: verif/scg_unit_model.sv */
// Behavioural model of a gated peripheral unit seen from the system bus
`timescale 1ns/10ps
`default_nettype none
module scg_unit_model (
   input wire logic aclk, // System clock
   input wire logic go, // Bench asks for one unit access
   input wire logic [8:0] go_sel, // One-hot unit for that access
   input wire logic unit_req_fault, // Fault answer from the gate block
   output logic unit_req_valid, // Access presented to the gate block
   output logic [8:0] unit_req_sel, // Unit select of the access
   output logic fault_seen // Fault taken with the last access
);
   initial begin
      unit_req_valid = 1'b0;
      unit_req_sel = 9'h000;
      fault_seen = 1'b0;
   end
   // One-cycle access; idle select toggles so a stale value is never trusted
   always @(posedge aclk) begin
      unit_req_valid <= go;
      unit_req_sel <= go ? go_sel : ~unit_req_sel;
   end
   // Stopped unit answers with a fault in the access cycle
   always @(posedge aclk) begin
      if (unit_req_valid) begin
         fault_seen <= unit_req_fault;
      end
   end
endmodule
`default_nettype wire

/* File: verif/sleep_clock_gating_control_test.sv */
// Self-checking bench for the sleep clock gating control block
`timescale 1ns/10ps
`default_nettype none
module sleep_clock_gating_control_test;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, unit_req_valid, unit_req_fault, irq, go, fault_seen;
   logic [31:0] awaddr, wdata, araddr, rdata, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, power_mode, rs;
   logic [8:0] unit_req_sel, unit_clk_en, go_sel;
   int failures = 0;
   int tests_run = 0;
   scg_sleep_gate_ctrl scg_sleep_gate_ctrl_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .power_mode(power_mode), .unit_req_valid(unit_req_valid), .unit_req_sel(unit_req_sel),
      .unit_req_fault(unit_req_fault), .unit_clk_en(unit_clk_en), .irq(irq));
   scg_unit_model scg_unit_model_i (.aclk(aclk), .go(go), .go_sel(go_sel), .unit_req_fault(unit_req_fault),
      .unit_req_valid(unit_req_valid), .unit_req_sel(unit_req_sel), .fault_seen(fault_seen));
   // Clock at 50 ns period
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   function automatic logic [31:0] adr(input logic [11:0] ofs);
      return scg_pkg::BASE_ADDR | {20'h00000, ofs};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Write both halves together, release each when taken, wait for response
   task automatic wr(input logic [11:0] ofs, input logic [31:0] d, input logic [1:0] exp);
      @(posedge aclk);
      awaddr <= adr(ofs);
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // No cycle count assumed; only the watchdog ends a hung wait
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, exp});
   endtask
   task automatic rdt(input logic [11:0] ofs);
      @(posedge aclk);
      araddr <= adr(ofs);
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   // Enables settle within two edges of a commit or mode change
   task automatic chk_en(input logic [8:0] exp);
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      chk({23'h0, unit_clk_en}, {23'h0, exp});
   endtask
   task automatic unit_access(input logic [8:0] sel, input logic exp);
      @(posedge aclk);
      go <= 1'b1;
      go_sel <= sel;
      @(posedge aclk);
      go <= 1'b0;
      @(posedge aclk);
      @(negedge aclk);
      chk({31'h0, fault_seen}, {31'h0, exp});
   endtask
   task automatic t_reset_map;
      rdt(scg_pkg::SLEEP_GATE_OFS);
      chk(rd, 32'h0000_0000);
      chk({23'h0, unit_clk_en}, 32'h0000_0000);
      wr(scg_pkg::SLEEP_GATE_OFS, 32'hffff_ffff, scg_pkg::RESP_OKAY);
      rdt(scg_pkg::SLEEP_GATE_OFS);
      chk(rd, 32'h5000_007f);
   endtask
   // Auto gate off keeps the run set; on applies the sleep set
   task automatic t_sleep_gate;
      power_mode <= scg_pkg::MODE_SLEEP;
      chk_en(9'h000);
      wr(scg_pkg::RUN_CFG_OFS, 32'h0800_0000, scg_pkg::RESP_OKAY);
      chk_en(9'h1ff);
      wr(scg_pkg::SLEEP_GATE_OFS, 32'h4000_0001, scg_pkg::RESP_OKAY);
      chk_en(9'h101);
      unit_access(9'h080, 1'b1);
      unit_access(9'h001, 1'b0);
      unit_access(9'h100, 1'b0);
   endtask
   task automatic t_modes;
      power_mode <= scg_pkg::MODE_RUN;
      chk_en(9'h000);
      wr(scg_pkg::RUN_GATE_OFS, 32'h1000_0000, scg_pkg::RESP_OKAY);
      chk_en(9'h080);
      power_mode <= scg_pkg::MODE_DEEP;
      chk_en(9'h000);
      power_mode <= scg_pkg::MODE_SLEEP;
      chk_en(9'h101);
   endtask
   // Sticky status, mask, read clear, refused accesses
   task automatic t_irq_err;
      rdt(scg_pkg::IRQ_STAT_OFS);
      chk(rd, 32'h0000_0003);
      chk({31'h0, irq}, 32'h0);
      wr(scg_pkg::IRQ_MASK_OFS, 32'h0000_0002, scg_pkg::RESP_OKAY);
      wr(scg_pkg::SLEEP_GATE_OFS, 32'h0000_0000, scg_pkg::RESP_OKAY);
      chk_en(9'h000);
      chk({31'h0, irq}, 32'h1);
      rdt(scg_pkg::IRQ_STAT_OFS);
      chk(rd, 32'h0000_0002);
      @(negedge aclk);
      chk({31'h0, irq}, 32'h0);
      rdt(12'h200);
      chk({30'h0, rs}, {30'h0, scg_pkg::RESP_SLVERR});
      chk(rd, 32'h0000_0000);
      wr(12'h204, 32'h0000_0001, scg_pkg::RESP_SLVERR);
      wr(scg_pkg::IRQ_STAT_OFS, 32'h0000_0003, scg_pkg::RESP_SLVERR);
      // Only lane 0 enabled: the upper enables must stay cleared
      wstrb <= 4'h1;
      wr(scg_pkg::SLEEP_GATE_OFS, 32'hffff_ffff, scg_pkg::RESP_OKAY);
      wstrb <= 4'hf;
      rdt(scg_pkg::SLEEP_GATE_OFS);
      chk(rd, 32'h0000_007f);
   endtask
   // Reset in mid-run clears enables that software had set
   task automatic t_mid_reset;
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rdt(scg_pkg::SLEEP_GATE_OFS);
      chk(rd, 32'h0000_0000);
      chk({23'h0, unit_clk_en}, 32'h0000_0000);
   endtask
   // Watchdog well beyond the expected run length
   initial begin
      #(3000 * 50);
      failures++;
      final_report();
   end
   initial begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, go} = 6'h00;
      awaddr = 32'h0;
      wdata = 32'h0;
      araddr = 32'h0;
      wstrb = 4'hf;
      go_sel = 9'h000;
      power_mode = scg_pkg::MODE_RUN;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset_map();
      t_sleep_gate();
      t_modes();
      t_irq_err();
      t_mid_reset();
      final_report();
   end
endmodule
`default_nettype wire
